// ===== tb/ipr_prio_regs_sva.sv
// Checker for the priority register bank ports.
`timescale 1ns/1ns
module ipr_prio_regs_sva (
   input wire logic        core_clk, srst, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0]  pstrb,
   input wire logic [2:0]  hostport_prio, outcmp8_prio, twowire2_master_prio,
   input wire logic [2:0]  twowire2_slave_prio, ext_int4_prio, ext_int3_prio,
   input wire logic [2:0]  clock_alarm_prio, checksum_err_prio, serial1_err_prio,
   input wire logic [13:0] src_enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic wr;
   logic rd;
   assign wr = psel && penable && pwrite && pready && pstrb[1:0] == 2'h3;
   assign rd = psel && penable && !pwrite && pready;
   a_reset_mid_level: assert property ($past(srst) |-> outcmp8_prio == 3'h4 &&
      checksum_err_prio == 3'h4 && src_enable == 14'h3fff) else $error("bad reset level");
   a_host_fields: assert property (wr && paddr == 12'h004 |=>
      {hostport_prio, outcmp8_prio} == {$past(pwdata[6:4]), $past(pwdata[2:0])})
      else $error("host port write");
   a_twowire_fields: assert property (wr && paddr == 12'h008 |=>
      {twowire2_master_prio, twowire2_slave_prio} == {$past(pwdata[10:8]), $past(pwdata[6:4])})
      else $error("two-wire write");
   a_ext_fields: assert property (wr && paddr == 12'h00c |=>
      {ext_int4_prio, ext_int3_prio} == {$past(pwdata[10:8]), $past(pwdata[6:4])})
      else $error("external write");
   a_crc_fields: assert property (wr && paddr == 12'h014 |=>
      {checksum_err_prio, serial1_err_prio} == {$past(pwdata[14:12]), $past(pwdata[6:4])})
      else $error("error field write");
   a_alarm_read: assert property (rd && paddr == 12'h010 |->
      prdata == {21'h0, clock_alarm_prio, 8'h0}) else $error("alarm read");
   a_host_read: assert property (rd && paddr == 12'h004 |->
      prdata == {25'h0, hostport_prio, 1'b0, outcmp8_prio}) else $error("host read");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response");
   a_disable_gate: assert property (src_enable[8] == (outcmp8_prio != 3'h0) &&
      src_enable[0] == (serial1_err_prio != 3'h0)) else $error("enable mismatch");
endmodule
bind ipr_prio_regs ipr_prio_regs_sva i_sva (.*);

// ===== tb/testbench.sv
// Self-checking bench for the priority register bank.
`timescale 1ns/1ns
module testbench;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'h0;
   logic [2:0]  hostport_prio, outcmp8_prio;
   logic [13:0] src_enable;
   int          n_mismatch = 0, n_compared = 0;
   logic [15:0] msk [6] = '{ipr_pkg::MASK_OUTCMP_CAPTURE, ipr_pkg::MASK_HOSTPORT_OUTCMP8,
      ipr_pkg::MASK_TWOWIRE2, ipr_pkg::MASK_EXT_INT34, ipr_pkg::MASK_RTC_ALARM,
      ipr_pkg::MASK_CRC_UART_ERR};
   ipr_prio_regs i_dut (.*, .outcmp6_prio(), .outcmp5_prio(), .capture6_prio(),
      .outcmp7_prio(), .twowire2_master_prio(), .twowire2_slave_prio(), .ext_int4_prio(),
      .ext_int3_prio(), .clock_alarm_prio(), .checksum_err_prio(), .serial2_err_prio(),
      .serial1_err_prio());
   initial forever #4 core_clk = ~core_clk;
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      @(negedge core_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 20) n_mismatch++;
      rd = prdata;
      err = pslverr;
      @(posedge core_clk);
   endtask
   initial begin
      repeat (2000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      logic [15:0] pat;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, 12'(i * 4), 32'h0, 4'h0);
         chk("reset value", {16'h0, msk[i] & 16'h4444}, rd);
      end
      $display("reset test done");
      for (int k = 0; k < 3; k++) begin
         pat = k == 0 ? 16'hffff : (k == 1 ? 16'h1111 : 16'h8888);
         for (int i = 0; i < 6; i++) xfer(1'b1, 12'(i * 4), {pat, pat}, 4'hf);
         for (int i = 0; i < 6; i++) begin
            xfer(1'b0, 12'(i * 4), 32'h0, 4'h0);
            chk("readback", {16'h0, pat & msk[i]}, rd);
         end
         chk("enables", {18'h0, k == 2 ? 14'h0 : 14'h3fff}, {18'h0, src_enable});
         chk("compare8", {29'h0, pat[2:0]}, {29'h0, outcmp8_prio});
         chk("hostport", {29'h0, pat[6:4]}, {29'h0, hostport_prio});
         $display("pattern test %0d done", k);
      end
      xfer(1'b1, 12'h008, 32'hffff, 4'h1);
      xfer(1'b0, 12'h008, 32'h0, 4'h0);
      chk("low strobe", 32'h0070, rd);
      xfer(1'b1, 12'h008, 32'hffff, 4'h2);
      xfer(1'b0, 12'h008, 32'h0, 4'h0);
      chk("high strobe", 32'h0770, rd);
      xfer(1'b1, 12'h018, 32'hffff, 4'hf);
      chk("unmapped write", 32'h1, {31'h0, err});
      xfer(1'b0, 12'h018, 32'h0, 4'h0);
      chk("unmapped read", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      $display("strobe and error test done");
      tally_and_finish();
   end
endmodule

// ===== verilog/ipr_pkg.sv
// Package of register offsets, field positions and reset values for the priority bank.
package ipr_pkg;

   localparam logic [11:0] ADDR_OUTCMP_CAPTURE  = 12'h000;
   localparam logic [11:0] ADDR_HOSTPORT_OUTCMP8 = 12'h004;
   localparam logic [11:0] ADDR_TWOWIRE2         = 12'h008;
   localparam logic [11:0] ADDR_EXT_INT34        = 12'h00c;
   localparam logic [11:0] ADDR_RTC_ALARM        = 12'h010;
   localparam logic [11:0] ADDR_CRC_UART_ERR     = 12'h014;

   localparam int POS_HI = 12;
   localparam int POS_MH = 8;
   localparam int POS_ML = 4;
   localparam int POS_LO = 0;

   localparam logic [2:0] PRIO_RESET    = 3'h4;
   localparam logic [2:0] PRIO_DISABLED = 3'h0;

   localparam logic [15:0] MASK_OUTCMP_CAPTURE   = 16'h7777;
   localparam logic [15:0] MASK_HOSTPORT_OUTCMP8 = 16'h0077;
   localparam logic [15:0] MASK_TWOWIRE2         = 16'h0770;
   localparam logic [15:0] MASK_EXT_INT34        = 16'h0770;
   localparam logic [15:0] MASK_RTC_ALARM        = 16'h0700;
   localparam logic [15:0] MASK_CRC_UART_ERR     = 16'h7770;

   localparam logic [15:0] RESET_OUTCMP_CAPTURE   = 16'h4444;
   localparam logic [15:0] RESET_HOSTPORT_OUTCMP8 = 16'h0044;
   localparam logic [15:0] RESET_TWOWIRE2         = 16'h0440;
   localparam logic [15:0] RESET_EXT_INT34        = 16'h0440;
   localparam logic [15:0] RESET_RTC_ALARM        = 16'h0400;
   localparam logic [15:0] RESET_CRC_UART_ERR     = 16'h4440;

   localparam int NUM_REGS = 6;

endpackage

// ===== verilog/ipr_prio_regs.sv
// APB register bank holding three-bit interrupt priority fields.
//
// Behaviour
// - Three-bit fields, code 111 means level 7.
// - Code 001 means level 1, lowest serviced.
// - Code 000 disables its source entirely.
// - Unimplemented bits read zero, ignore writes.
// - Compare channel 8 uses low three bits.
// - Two-wire master bits 10-8, slave 6-4.
// - External interrupt 4 in bits 10-8.
// - External interrupt 3 in bits 6-4.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ns
module ipr_prio_regs (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   output logic [2:0]       outcmp6_prio,
   output logic [2:0]       outcmp5_prio,
   output logic [2:0]       capture6_prio,
   output logic [2:0]       outcmp7_prio,
   output logic [2:0]       hostport_prio,
   output logic [2:0]       outcmp8_prio,
   output logic [2:0]       twowire2_master_prio,
   output logic [2:0]       twowire2_slave_prio,
   output logic [2:0]       ext_int4_prio,
   output logic [2:0]       ext_int3_prio,
   output logic [2:0]       clock_alarm_prio,
   output logic [2:0]       checksum_err_prio,
   output logic [2:0]       serial2_err_prio,
   output logic [2:0]       serial1_err_prio,
   output logic [13:0]      src_enable
);

   typedef struct packed {
      logic [15:0] outcmpCapture;
      logic [15:0] hostportOutcmp8;
      logic [15:0] twowire2;
      logic [15:0] extInt34;
      logic [15:0] rtcAlarm;
      logic [15:0] crcUartErr;
      logic        ready;
      logic        slvErr;
      logic [31:0] rdata;
      logic [13:0] enable;
   } ipr_state_t;

   ipr_state_t state_q;
   ipr_state_t state_d;

   // Expands the two low byte strobes into a mask of sixteen bit lanes.
   function automatic logic [15:0] ipr_lanes(input logic [3:0] strb);
      logic [15:0] be;
      be = {{8{strb[1]}}, {8{strb[0]}}};
      return be;
   endfunction

   // Merges a write into a register, keeping only implemented bits.
   function automatic logic [15:0] ipr_merge(input logic [15:0] cur,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [15:0] mask);
      logic [15:0] be;
      logic [15:0] kept;
      logic [15:0] taken;
      be    = ipr_lanes(strb);
      kept  = cur & ~be;
      taken = wdata[15:0] & be;
      return (kept | taken) & mask;
   endfunction

   // Returns a field of three bits at the given position.
   function automatic logic [2:0] ipr_field(input logic [15:0] r,
                                            input int          pos);
      return r[pos +: 3];
   endfunction

   // A source is enabled when its field is not all zeros.
   function automatic logic ipr_on(input logic [2:0] f);
      return f != ipr_pkg::PRIO_DISABLED;
   endfunction

   // Tells whether an address selects one of the six registers.
   function automatic logic ipr_known(input logic [11:0] addr);
      logic hit;
      hit = 1'b0;
      case (addr)
         ipr_pkg::ADDR_OUTCMP_CAPTURE: begin
            hit = 1'b1;
         end

         ipr_pkg::ADDR_HOSTPORT_OUTCMP8: begin
            hit = 1'b1;
         end

         ipr_pkg::ADDR_TWOWIRE2: begin
            hit = 1'b1;
         end

         ipr_pkg::ADDR_EXT_INT34: begin
            hit = 1'b1;
         end

         ipr_pkg::ADDR_RTC_ALARM: begin
            hit = 1'b1;
         end

         ipr_pkg::ADDR_CRC_UART_ERR: begin
            hit = 1'b1;
         end

         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   // Returns the read word of the register at an address, zero elsewhere.
   function automatic logic [31:0] ipr_read(input ipr_state_t  s,
                                            input logic [11:0] addr);
      logic [15:0] word;
      word = 16'h0000;
      case (addr)
         ipr_pkg::ADDR_OUTCMP_CAPTURE: begin
            word = s.outcmpCapture;
         end

         ipr_pkg::ADDR_HOSTPORT_OUTCMP8: begin
            word = s.hostportOutcmp8;
         end

         ipr_pkg::ADDR_TWOWIRE2: begin
            word = s.twowire2;
         end

         ipr_pkg::ADDR_EXT_INT34: begin
            word = s.extInt34;
         end

         ipr_pkg::ADDR_RTC_ALARM: begin
            word = s.rtcAlarm;
         end

         ipr_pkg::ADDR_CRC_UART_ERR: begin
            word = s.crcUartErr;
         end

         default: begin
            word = 16'h0000;
         end
      endcase
      return {16'h0000, word};
   endfunction

   // Collects the enable bit of every field, outcmp7 first and serial1 last.
   function automatic logic [13:0] ipr_enables(input ipr_state_t s);
      logic [13:0] en;
      en[13] = ipr_on(ipr_field(s.outcmpCapture, ipr_pkg::POS_HI));
      en[12] = ipr_on(ipr_field(s.outcmpCapture, ipr_pkg::POS_MH));
      en[11] = ipr_on(ipr_field(s.outcmpCapture, ipr_pkg::POS_ML));
      en[10] = ipr_on(ipr_field(s.outcmpCapture, ipr_pkg::POS_LO));
      en[9]  = ipr_on(ipr_field(s.hostportOutcmp8, ipr_pkg::POS_ML));
      en[8]  = ipr_on(ipr_field(s.hostportOutcmp8, ipr_pkg::POS_LO));
      en[7]  = ipr_on(ipr_field(s.twowire2, ipr_pkg::POS_MH));
      en[6]  = ipr_on(ipr_field(s.twowire2, ipr_pkg::POS_ML));
      en[5]  = ipr_on(ipr_field(s.extInt34, ipr_pkg::POS_MH));
      en[4]  = ipr_on(ipr_field(s.extInt34, ipr_pkg::POS_ML));
      en[3]  = ipr_on(ipr_field(s.rtcAlarm, ipr_pkg::POS_MH));
      en[2]  = ipr_on(ipr_field(s.crcUartErr, ipr_pkg::POS_HI));
      en[1]  = ipr_on(ipr_field(s.crcUartErr, ipr_pkg::POS_MH));
      en[0]  = ipr_on(ipr_field(s.crcUartErr, ipr_pkg::POS_ML));
      return en;
   endfunction

   logic access;
   logic setup;
   logic known;

   always_comb begin
      state_d        = state_q;
      access         = psel && penable;
      setup          = psel && !penable;
      known          = ipr_known(paddr);
      state_d.ready  = setup;
      state_d.slvErr = 1'b0;

      if (setup) begin
         state_d.slvErr = !known;
         state_d.rdata  = 32'h0000_0000;
         if (!pwrite) begin
            state_d.rdata = ipr_read(state_q, paddr);
         end
      end

      if (access && state_q.ready && pwrite && known) begin
         case (paddr)
            ipr_pkg::ADDR_OUTCMP_CAPTURE: begin
               state_d.outcmpCapture = ipr_merge(state_q.outcmpCapture,
                                                 pwdata,
                                                 pstrb,
                                                 ipr_pkg::MASK_OUTCMP_CAPTURE);
            end

            ipr_pkg::ADDR_HOSTPORT_OUTCMP8: begin
               state_d.hostportOutcmp8 = ipr_merge(state_q.hostportOutcmp8,
                                                   pwdata,
                                                   pstrb,
                                                   ipr_pkg::MASK_HOSTPORT_OUTCMP8);
            end

            ipr_pkg::ADDR_TWOWIRE2: begin
               state_d.twowire2 = ipr_merge(state_q.twowire2,
                                            pwdata,
                                            pstrb,
                                            ipr_pkg::MASK_TWOWIRE2);
            end

            ipr_pkg::ADDR_EXT_INT34: begin
               state_d.extInt34 = ipr_merge(state_q.extInt34,
                                            pwdata,
                                            pstrb,
                                            ipr_pkg::MASK_EXT_INT34);
            end

            ipr_pkg::ADDR_RTC_ALARM: begin
               state_d.rtcAlarm = ipr_merge(state_q.rtcAlarm,
                                            pwdata,
                                            pstrb,
                                            ipr_pkg::MASK_RTC_ALARM);
            end

            ipr_pkg::ADDR_CRC_UART_ERR: begin
               state_d.crcUartErr = ipr_merge(state_q.crcUartErr,
                                              pwdata,
                                              pstrb,
                                              ipr_pkg::MASK_CRC_UART_ERR);
            end

            default: begin
               state_d.crcUartErr = state_q.crcUartErr;
            end
         endcase
      end

      state_d.enable = ipr_enables(state_d);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q                 <= '0;
         state_q.outcmpCapture   <= ipr_pkg::RESET_OUTCMP_CAPTURE;
         state_q.hostportOutcmp8 <= ipr_pkg::RESET_HOSTPORT_OUTCMP8;
         state_q.twowire2        <= ipr_pkg::RESET_TWOWIRE2;
         state_q.extInt34        <= ipr_pkg::RESET_EXT_INT34;
         state_q.rtcAlarm        <= ipr_pkg::RESET_RTC_ALARM;
         state_q.crcUartErr      <= ipr_pkg::RESET_CRC_UART_ERR;
         state_q.enable          <= 14'h3fff;
      end else begin
         state_q <= state_d;
      end
   end

   assign pready               = state_q.ready;
   assign pslverr              = state_q.slvErr;
   assign prdata               = state_q.rdata;
   assign outcmp7_prio         = ipr_field(state_q.outcmpCapture, ipr_pkg::POS_HI);
   assign outcmp6_prio         = ipr_field(state_q.outcmpCapture, ipr_pkg::POS_MH);
   assign outcmp5_prio         = ipr_field(state_q.outcmpCapture, ipr_pkg::POS_ML);
   assign capture6_prio        = ipr_field(state_q.outcmpCapture, ipr_pkg::POS_LO);
   assign hostport_prio        = ipr_field(state_q.hostportOutcmp8, ipr_pkg::POS_ML);
   assign outcmp8_prio         = ipr_field(state_q.hostportOutcmp8, ipr_pkg::POS_LO);
   assign twowire2_master_prio = ipr_field(state_q.twowire2, ipr_pkg::POS_MH);
   assign twowire2_slave_prio  = ipr_field(state_q.twowire2, ipr_pkg::POS_ML);
   assign ext_int4_prio        = ipr_field(state_q.extInt34, ipr_pkg::POS_MH);
   assign ext_int3_prio        = ipr_field(state_q.extInt34, ipr_pkg::POS_ML);
   assign clock_alarm_prio     = ipr_field(state_q.rtcAlarm, ipr_pkg::POS_MH);
   assign checksum_err_prio    = ipr_field(state_q.crcUartErr, ipr_pkg::POS_HI);
   assign serial2_err_prio     = ipr_field(state_q.crcUartErr, ipr_pkg::POS_MH);
   assign serial1_err_prio     = ipr_field(state_q.crcUartErr, ipr_pkg::POS_ML);
   assign src_enable           = state_q.enable;

endmodule
